// file: core/fpac_defines.vh
`ifndef FPAC_DEFINES_VH
`define FPAC_DEFINES_VH
// Register byte addresses
`define FPAC_ADR_CTRL 8'h00
`define FPAC_ADR_CODE 8'h04
`define FPAC_ADR_QUICK 8'h08
`define FPAC_ADR_STAT 8'h0c
`define FPAC_ADR_KEYIN 8'h10
`define FPAC_ADR_SVC 8'h14
// Control fields
`define FPAC_SEL_EN 0
`define FPAC_SCROLL_EN 1
`define FPAC_UIN_HIGH 2
`define FPAC_CNT_B_EN 3
`define FPAC_RST_LO 4
`define FPAC_RST_HI 6
`define FPAC_INT_LO 8
`define FPAC_INT_HI 10
`define FPAC_UFN_LO 12
`define FPAC_UFN_HI 13
`define FPAC_SVC_EN 16
// Reset-key choices
`define FPAC_RK_NONE 3'h0
`define FPAC_RK_A 3'h1
`define FPAC_RK_B 3'h2
`define FPAC_RK_BOTH 3'h3
`define FPAC_RK_DISP 3'h4
// User input functions
`define FPAC_UF_NONE 2'h0
`define FPAC_UF_LOCK 2'h1
`define FPAC_UF_DSEL 2'h2
`define FPAC_UF_INT 2'h3
// Defaults
`define FPAC_CTRL_RST 32'h0000_3105
`define FPAC_INT_DEF 3'h3
`define FPAC_INT_MIN 3'h1
`define FPAC_INT_MAX 3'h5
// Codes
`define FPAC_CODE_MAX 10'h3e7
`define FPAC_QUICK_MAX 10'h063
`define FPAC_CODE_MASTER 10'h0de
`define FPAC_CODE_MODEL 10'h032
`define FPAC_CODE_DEFLT 10'h042
`define FPAC_NDISP 3'h4
// Scroll timing
`define FPAC_CLK_HZ 200000000
`define FPAC_SCROLL_S 4
`define FPAC_SCROLL_CYC (`FPAC_CLK_HZ * `FPAC_SCROLL_S)
`endif

// file: core/fpac_edge.v
`timescale 1ns/100ps
// Rising-edge detector for a synchronous level
module fpac_edge (
  input wire clk_sys_i, // system clock
  input wire rstn_i, // async reset, active low
  input wire ce_i, // clock enable
  input wire lvl_i, // level in
  output reg rise_o // one-cycle pulse on rising level
);
  reg prev_reg;
  always @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      prev_reg <= 1'b0;
      rise_o <= 1'b0;
    end else if (ce_i) begin
      prev_reg <= lvl_i;
      rise_o <= lvl_i & ~prev_reg;
    end
  end
endmodule

// file: core/fpac_scroll.v
`timescale 1ns/100ps
`include "fpac_defines.vh"
// Display scroll timer: one pulse per dwell period while enabled
module fpac_scroll #(
  parameter [31:0] DWELL_CYC = `FPAC_SCROLL_CYC
) (
  input wire clk_sys_i, // system clock
  input wire rstn_i, // async reset, active low
  input wire ce_i, // clock enable
  input wire en_i, // scroll enabled
  output reg tick_o // advance pulse
);
  reg [31:0] cnt_reg;
  always @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_reg <= 32'h0;
      tick_o <= 1'b0;
    end else if (ce_i) begin
      tick_o <= 1'b0;
      if (!en_i) begin
        cnt_reg <= 32'h0;
      end else if (cnt_reg == DWELL_CYC - 32'h1) begin
        cnt_reg <= 32'h0;
        tick_o <= 1'b1;
      end else begin
        cnt_reg <= cnt_reg + 32'h1;
      end
    end
  end
endmodule

// file: core/fpac_top.v
`timescale 1ns/100ps
`include "fpac_defines.vh"
module fpac_top #(
  parameter [31:0] SCROLL_CYC = `FPAC_SCROLL_CYC,
  parameter [7:0] MODEL_VER = 8'h11 // arbitrary value
) (
  input wire clk_sys_i, // system clock 200 MHz
  input wire rstn_i, // async reset, active low
  input wire ce_i, // clock enable
  input wire key_sel_i, // select key level
  input wire key_rst_i, // reset key level
  input wire parameter_key_i, // parameter key level
  input wire user_in_i, // user input line
  input wire [3:0] disp_en_i, // enabled displays mask
  input wire [31:0] wb_adr_i, // wishbone address
  input wire [31:0] wb_dat_i, // wishbone write data
  input wire [3:0] wb_sel_i, // wishbone byte selects
  input wire wb_we_i, // wishbone write enable
  input wire wb_cyc_i, // wishbone cycle
  input wire wb_stb_i, // wishbone strobe
  output reg [31:0] wb_dat_o, // wishbone read data
  output reg wb_ack_o, // wishbone acknowledge
  output reg [1:0] disp_sel_o, // display shown
  output reg [2:0] intensity_o, // brightness level
  output reg cnt_a_rst_o, // counter A reset pulse
  output reg cnt_b_rst_o, // counter B reset pulse
  output reg [2:0] mode_o, // 0 run,1 quick,2 prompt,3 full,4 lock
  output reg show_model_o, // model/version shown
  output reg [7:0] model_ver_o, // model and version value
  output reg show_reset_o, // reset message shown
  output reg defaults_o // factory default restore pulse
);
  localparam [4:0] ST_RUN = 5'h01;
  localparam [4:0] ST_QUICK = 5'h02;
  localparam [4:0] ST_PROMPT = 5'h04;
  localparam [4:0] ST_FULL = 5'h08;
  localparam [4:0] ST_LOCK = 5'h10;

  reg [31:0] ctrl_reg;
  reg [9:0] code_reg;
  reg [3:0] quick_reg;
  reg [9:0] keyin_reg;
  reg keyin_stb_reg;
  reg [4:0] st_reg;
  reg [4:0] st_next;
  reg [1:0] qidx_reg;
  wire key_sel_rise;
  wire key_rst_rise;
  wire par_rise;
  wire uin_rise;
  wire scroll_tick;
  wire uin_act;
  wire uf_lock;
  wire locked;
  wire quick_on;
  wire [2:0] rk;
  wire [2:0] int_fld;
  wire wb_hit;
  wire adv;
  reg [1:0] next_disp;
  integer i;

  assign uin_act = user_in_i ~^ ctrl_reg[`FPAC_UIN_HIGH];
  assign uf_lock = ctrl_reg[`FPAC_UFN_HI:`FPAC_UFN_LO] == `FPAC_UF_LOCK;
  assign locked = uf_lock & uin_act;
  assign quick_on = (code_reg != 10'h0) && (code_reg <= `FPAC_QUICK_MAX);
  assign rk = ctrl_reg[`FPAC_RST_HI:`FPAC_RST_LO];
  assign int_fld = ctrl_reg[`FPAC_INT_HI:`FPAC_INT_LO];
  assign wb_hit = wb_cyc_i & wb_stb_i & ~wb_ack_o;

  fpac_edge u_sel (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .ce_i(ce_i), .lvl_i(key_sel_i), .rise_o(key_sel_rise));
  fpac_edge u_rst (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .ce_i(ce_i), .lvl_i(key_rst_i), .rise_o(key_rst_rise));
  fpac_edge u_par (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .ce_i(ce_i), .lvl_i(parameter_key_i),
    .rise_o(par_rise));
  fpac_edge u_uin (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .ce_i(ce_i), .lvl_i(uin_act),
    .rise_o(uin_rise));
  fpac_scroll #(.DWELL_CYC(SCROLL_CYC)) u_scr (
    .clk_sys_i(clk_sys_i),
    .rstn_i(rstn_i),
    .ce_i(ce_i),
    .en_i(ctrl_reg[`FPAC_SCROLL_EN] & (st_reg == ST_RUN)),
    .tick_o(scroll_tick)
  );

  // Select key, user-input select, or scroll timer advance the display
  assign adv = (st_reg == ST_RUN) & ((key_sel_rise & ctrl_reg[`FPAC_SEL_EN])
    | (uin_rise & (ctrl_reg[`FPAC_UFN_HI:`FPAC_UFN_LO] == `FPAC_UF_DSEL))
    | scroll_tick);

  // Next enabled display after the current one, wrapping
  always @* begin
    next_disp = disp_sel_o;
    for (i = `FPAC_NDISP - 1; i >= 1; i = i - 1) begin
      if (disp_en_i[disp_sel_o + i[1:0]]) begin
        next_disp = disp_sel_o + i[1:0];
      end
    end
  end

  // Access state machine
  always @* begin
    st_next = st_reg;
    case (st_reg)
      ST_RUN: begin
        if (par_rise) begin
          if (!uf_lock || !uin_act) begin
            st_next = (code_reg == 10'h0 || uf_lock) ? ST_FULL : (quick_on ? ST_QUICK : ST_PROMPT);
          end else if (code_reg == 10'h0) begin
            st_next = ST_LOCK;
          end else begin
            st_next = quick_on ? ST_QUICK : ST_PROMPT;
          end
        end
      end
      ST_QUICK: begin
        if (par_rise && (qidx_reg == 2'h3)) begin
          st_next = locked ? ST_RUN : ST_PROMPT;
        end
      end
      ST_PROMPT: begin
        if (keyin_stb_reg) begin
          // Service codes show their result and keep the code entry prompt up
          if (ctrl_reg[`FPAC_SVC_EN] && (keyin_reg == `FPAC_CODE_MODEL || keyin_reg == `FPAC_CODE_DEFLT)) begin
            st_next = ST_PROMPT;
          end else if (keyin_reg == `FPAC_CODE_MASTER || keyin_reg == code_reg) begin
            st_next = ST_FULL;
          end else begin
            st_next = ST_RUN;
          end
        end else if (par_rise) begin
          st_next = ST_RUN;
        end
      end
      ST_FULL: begin
        if (par_rise) begin
          st_next = ST_RUN;
        end
      end
      ST_LOCK: begin
        st_next = ST_RUN;
      end
      default: begin
        st_next = ST_RUN;
      end
    endcase
  end

  always @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_reg <= ST_RUN;
      qidx_reg <= 2'h0;
      mode_o <= 3'h0;
      disp_sel_o <= 2'h0;
      intensity_o <= `FPAC_INT_DEF;
      cnt_a_rst_o <= 1'b0;
      cnt_b_rst_o <= 1'b0;
      show_model_o <= 1'b0;
      model_ver_o <= 8'h0;
      show_reset_o <= 1'b0;
      defaults_o <= 1'b0;
    end else if (ce_i) begin
      st_reg <= st_next;
      // Quick list walks all four entries, one per parameter key press
      if (st_reg != ST_QUICK) begin
        qidx_reg <= 2'h0;
      end else if (par_rise) begin
        qidx_reg <= qidx_reg + 2'h1;
      end
      case (st_next)
        ST_QUICK: mode_o <= 3'h1;
        ST_PROMPT: mode_o <= 3'h2;
        ST_FULL: mode_o <= 3'h3;
        ST_LOCK: mode_o <= 3'h4;
        default: mode_o <= 3'h0;
      endcase
      if (adv) begin
        disp_sel_o <= next_disp;
      end
      intensity_o <= int_fld;
      cnt_a_rst_o <= key_rst_rise & (st_reg == ST_RUN) & ((rk == `FPAC_RK_A) | (rk == `FPAC_RK_BOTH)
        | ((rk == `FPAC_RK_DISP) & (disp_sel_o == 2'h0)));
      cnt_b_rst_o <= key_rst_rise & (st_reg == ST_RUN) & ctrl_reg[`FPAC_CNT_B_EN]
        & ((rk == `FPAC_RK_B) | (rk == `FPAC_RK_BOTH) | ((rk == `FPAC_RK_DISP) & (disp_sel_o == 2'h1)));
      model_ver_o <= MODEL_VER;
      defaults_o <= 1'b0;
      if (st_reg == ST_PROMPT && keyin_stb_reg && ctrl_reg[`FPAC_SVC_EN]) begin
        show_model_o <= keyin_reg == `FPAC_CODE_MODEL;
        show_reset_o <= keyin_reg == `FPAC_CODE_DEFLT;
        defaults_o <= keyin_reg == `FPAC_CODE_DEFLT;
      end else if (par_rise) begin
        show_model_o <= 1'b0;
        show_reset_o <= 1'b0;
      end
    end
  end

  // Register file; factory restore and user-input intensity step also write it
  always @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ctrl_reg <= `FPAC_CTRL_RST;
      code_reg <= 10'h0;
      quick_reg <= 4'h0;
      keyin_reg <= 10'h0;
      keyin_stb_reg <= 1'b0;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else if (ce_i) begin
      wb_ack_o <= wb_hit;
      keyin_stb_reg <= 1'b0;
      if (defaults_o) begin
        ctrl_reg <= `FPAC_CTRL_RST;
        code_reg <= 10'h0;
        quick_reg <= 4'h0;
      end else if (wb_hit && wb_we_i) begin
        case (wb_adr_i[7:0])
          `FPAC_ADR_CTRL: begin
            if (wb_sel_i[0]) ctrl_reg[7:0] <= wb_dat_i[7:0];
            if (wb_sel_i[1]) begin
              if (wb_dat_i[`FPAC_INT_HI:`FPAC_INT_LO] >= `FPAC_INT_MIN
                && wb_dat_i[`FPAC_INT_HI:`FPAC_INT_LO] <= `FPAC_INT_MAX) begin
                ctrl_reg[15:8] <= wb_dat_i[15:8];
              end else begin
                ctrl_reg[15:11] <= wb_dat_i[15:11];
              end
            end
            if (wb_sel_i[2]) ctrl_reg[23:16] <= wb_dat_i[23:16];
          end
          `FPAC_ADR_CODE: begin
            if (wb_sel_i[0] && wb_sel_i[1] && wb_dat_i[9:0] <= `FPAC_CODE_MAX) begin
              code_reg <= wb_dat_i[9:0];
            end
          end
          `FPAC_ADR_QUICK: begin
            if (wb_sel_i[0]) quick_reg <= wb_dat_i[3:0];
          end
          `FPAC_ADR_KEYIN: begin
            if (wb_sel_i[0] && wb_sel_i[1]) begin
              keyin_reg <= wb_dat_i[9:0];
              keyin_stb_reg <= 1'b1;
            end
          end
          default: begin
          end
        endcase
      end else if (uin_rise && ctrl_reg[`FPAC_UFN_HI:`FPAC_UFN_LO] == `FPAC_UF_INT) begin
        ctrl_reg[`FPAC_INT_HI:`FPAC_INT_LO] <= (int_fld == `FPAC_INT_MAX) ? `FPAC_INT_MIN
          : int_fld + 3'h1;
      end
      if (wb_hit && !wb_we_i) begin
        case (wb_adr_i[7:0])
          `FPAC_ADR_CTRL: wb_dat_o <= ctrl_reg;
          `FPAC_ADR_CODE: wb_dat_o <= {22'h0, code_reg};
          `FPAC_ADR_QUICK: wb_dat_o <= {28'h0, quick_reg};
          `FPAC_ADR_STAT: wb_dat_o <= {16'h0, 3'h0, st_reg, 2'h0, locked, quick_on, 2'h0, disp_sel_o};
          `FPAC_ADR_KEYIN: wb_dat_o <= {22'h0, keyin_reg};
          `FPAC_ADR_SVC: wb_dat_o <= {22'h0, show_reset_o, show_model_o, model_ver_o};
          default: wb_dat_o <= 32'h0;
        endcase
      end
    end
  end
endmodule

// file: verification/fpac_monitor.sv
`timescale 1ns/100ps
module fpac_mon #(
  parameter [7:0] MODEL_VER = 8'h11 // arbitrary
) (
  input wire clk_sys_i, // clock
  input wire rstn_i, // reset
  input wire ce_i, // enable
  input wire key_rst_i, // reset key
  input wire wb_cyc_i, // cycle
  input wire wb_stb_i, // strobe
  input wire wb_ack_o, // ack
  input wire [2:0] intensity_o, // level
  input wire cnt_a_rst_o, // A reset
  input wire cnt_b_rst_o, // B reset
  input wire [2:0] mode_o, // mode
  input wire show_model_o, // model
  input wire [7:0] model_ver_o, // value
  input wire show_reset_o, // message
  input wire defaults_o // restore
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i |=> wb_ack_o)
    else $error("bus request not answered");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  a_int_range: assert property (intensity_o >= 3'h1 && intensity_o <= 3'h5)
    else $error("intensity out of range");
  a_mode_legal: assert property (mode_o <= 3'h4)
    else $error("illegal mode");
  a_lock_brief: assert property (mode_o == 3'h4 |=> mode_o == 3'h0)
    else $error("lock not left");
  a_rst_cause: assert property (cnt_a_rst_o || cnt_b_rst_o |-> $past(key_rst_i, 1) || $past(key_rst_i, 2))
    else $error("counter reset without key");
  a_rst_pulse: assert property (cnt_a_rst_o |=> !cnt_a_rst_o)
    else $error("reset pulse too long");
  a_svc_stay: assert property ($rose(show_model_o) |-> mode_o == 3'h2)
    else $error("service code left prompt");
  a_model_val: assert property (show_model_o |-> model_ver_o == MODEL_VER)
    else $error("wrong model value");
  a_dflt_msg: assert property ($rose(defaults_o) |-> ##[0:3] show_reset_o)
    else $error("no reset message");
  a_dflt_pulse: assert property (defaults_o |=> !defaults_o)
    else $error("restore pulse too long");
endmodule
bind fpac_top fpac_mon #(.MODEL_VER(MODEL_VER)) i_fpac_mon (.clk_sys_i, .rstn_i, .ce_i, .key_rst_i, .wb_cyc_i,
  .wb_stb_i, .wb_ack_o, .intensity_o, .cnt_a_rst_o, .cnt_b_rst_o, .mode_o, .show_model_o, .model_ver_o,
  .show_reset_o, .defaults_o);

// file: verification/fpac_keys.sv
`timescale 1ns/100ps
module fpac_keys (
  input wire clk_sys_i, // clock
  output logic key_sel_o, // select key
  output logic key_rst_o, // reset key
  output logic par_key_o, // parameter key
  output logic user_in_o // user input
);
  initial {key_sel_o, key_rst_o, par_key_o, user_in_o} = 4'h0;
  task automatic tap(input int k);
    @(posedge clk_sys_i);
    case (k)
      0: key_sel_o <= 1'b1;
      1: key_rst_o <= 1'b1;
      default: par_key_o <= 1'b1;
    endcase
    repeat (3) @(posedge clk_sys_i);
    {key_sel_o, key_rst_o, par_key_o} <= 3'h0;
    repeat (4) @(posedge clk_sys_i);
  endtask
  task automatic level(input logic v);
    @(posedge clk_sys_i);
    user_in_o <= v;
  endtask
endmodule

// file: verification/tb.sv
`timescale 1ns/100ps
`include "fpac_defines.vh"
module tb;
  localparam int DW = 20;
  localparam [7:0] MV = 8'h11; // arbitrary
  logic clk_sys_i = 0, rstn_i = 0, wb_we_i = 0, wb_cyc_i = 0, wb_stb_i = 0, ce = 1;
  logic [3:0] sel = 4'hf;
  logic [3:0] disp_en_i = 4'hf, wb_sel_i = 4'h0;
  logic [31:0] wb_adr_i = 0, wb_dat_i = 0, wb_dat_o, rd;
  logic wb_ack_o, ks, kr, kp, ui, ca, cb, smod, srst, dflt;
  logic [1:0] disp;
  logic [2:0] inten, mode;
  logic [7:0] mv, mvs;
  int n_fail, n_compared, cyc, na, nb, nlk, nmd, ndf, nms;
  fpac_keys i_fpac_keys (.clk_sys_i, .key_sel_o(ks), .key_rst_o(kr), .par_key_o(kp), .user_in_o(ui));
  fpac_top #(.SCROLL_CYC(DW), .MODEL_VER(MV)) i_fpac_top (.clk_sys_i, .rstn_i, .ce_i(ce), .key_sel_i(ks),
    .key_rst_i(kr), .parameter_key_i(kp), .user_in_i(ui), .disp_en_i, .wb_adr_i, .wb_dat_i, .wb_sel_i,
    .wb_we_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .disp_sel_o(disp), .intensity_o(inten),
    .cnt_a_rst_o(ca), .cnt_b_rst_o(cb), .mode_o(mode), .show_model_o(smod), .model_ver_o(mv),
    .show_reset_o(srst), .defaults_o(dflt));
  initial forever #2.5 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    na <= na + (ca === 1'b1);
    nb <= nb + (cb === 1'b1);
    nlk <= nlk + (mode === 3'h4);
    nmd <= nmd + (smod === 1'b1);
    ndf <= ndf + (dflt === 1'b1);
    nms <= nms + (srst === 1'b1);
    if (smod === 1'b1)
      mvs <= mv;
    if (cyc == 20000) begin
      n_fail++;
      report_and_stop();
    end
  end
  task automatic chk(input string nm, input logic [31:0] s, e);
    n_compared++;
    if (s !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i} <= {2'h3, we, sel};
    wb_adr_i <= {24'h0, a};
    wb_dat_i <= d;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    rd = wb_dat_o;
    chk("ack", n < 50, 1);
    {wb_cyc_i, wb_stb_i, wb_sel_i} <= 6'h0;
  endtask
  task automatic do_reset();
    @(posedge clk_sys_i);
    rstn_i <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    rstn_i <= 1'b1;
  endtask
  task automatic acc(input string nm, input logic [31:0] c, input logic [9:0] code, input logic u, int np,
    input logic [2:0] em);
    do_reset();
    wb(1, `FPAC_ADR_CTRL, c);
    wb(1, `FPAC_ADR_CODE, {22'h0, code});
    i_fpac_keys.level(u);
    repeat (np) i_fpac_keys.tap(2);
    chk(nm, mode, em);
  endtask
  task automatic key(input logic [9:0] code);
    wb(1, `FPAC_ADR_KEYIN, {22'h0, code});
    repeat (3) @(posedge clk_sys_i);
  endtask
  task automatic s_regs();
    wb(0, `FPAC_ADR_CTRL, 0);
    chk("ctrl", rd, `FPAC_CTRL_RST);
    wb(1, 8'h20, 32'hffff_ffff);
    wb(0, 8'h20, 0);
    chk("unmapped", rd, 0);
    wb(1, `FPAC_ADR_CODE, 32'h3e7);
    wb(1, `FPAC_ADR_CODE, 32'h3e8);
    wb(0, `FPAC_ADR_CODE, 0);
    chk("code", rd, 32'h3e7);
    sel = 4'h1;
    wb(1, `FPAC_ADR_CODE, 32'h005);
    sel = 4'hf;
    wb(0, `FPAC_ADR_CODE, 0);
    chk("code sel", rd, 32'h3e7);
    wb(1, `FPAC_ADR_QUICK, 32'hff);
    wb(0, `FPAC_ADR_QUICK, 0);
    chk("quick", rd, 32'hf);
    for (int i = 0; i < 3; i++) begin
      wb(1, `FPAC_ADR_CTRL, 32'h0405 + (i << 8));
      repeat (2) @(posedge clk_sys_i);
      chk("int", inten, i == 0 ? 4 : 5);
    end
  endtask
  task automatic s_sel();
    i_fpac_keys.tap(0);
    chk("sel", disp, 1);
    disp_en_i <= 4'h9;
    i_fpac_keys.tap(0);
    chk("skip", disp, 3);
    wb(1, `FPAC_ADR_CTRL, 32'h2105);
    i_fpac_keys.level(1);
    repeat (8) @(posedge clk_sys_i);
    chk("uin", disp, 0);
    i_fpac_keys.level(0);
    disp_en_i <= 4'hf;
  endtask
  task automatic s_ce();
    int d;
    d = disp;
    ce <= 1'b0;
    i_fpac_keys.tap(0);
    chk("frozen", disp, d);
    ce <= 1'b1;
    i_fpac_keys.tap(0);
    chk("thawed", disp, (d + 1) % 4);
  endtask
  task automatic s_step();
    wb(1, `FPAC_ADR_CTRL, 32'h3405);
    for (int i = 0; i < 2; i++) begin
      i_fpac_keys.level(1);
      repeat (4) @(posedge clk_sys_i);
      chk("step", inten, i == 0 ? 5 : 1);
      i_fpac_keys.level(0);
    end
  endtask
  task automatic s_rst();
    int ea, eb, c;
    do_reset();
    for (int i = 0; i < 10; i++) begin
      c = i % 5;
      ea = na + (c == 1 || c == 3 || c == 4);
      eb = nb + (i > 4 && (c == 2 || c == 3));
      wb(1, `FPAC_ADR_CTRL, 32'h0105 | (c << 4) | ((i / 5) << 3));
      i_fpac_keys.tap(1);
      chk("rst a", na, ea);
      chk("rst b", nb, eb);
    end
    i_fpac_keys.tap(0);
    i_fpac_keys.tap(1);
    chk("disp b", nb, eb + 1);
  endtask
  task automatic s_scroll();
    int t;
    wb(1, `FPAC_ADR_CTRL, 32'h0107);
    @(disp);
    @(negedge clk_sys_i);
    t = cyc;
    @(disp);
    @(negedge clk_sys_i);
    chk("dwell", cyc - t, DW);
  endtask
  task automatic report_and_stop();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    s_regs();
    s_sel();
    s_ce();
    s_step();
    s_rst();
    s_scroll();
    acc("full", 32'h0105, 0, 0, 1, 3);
    acc("quick", 32'h0105, 50, 0, 1, 1);
    acc("list", 32'h0105, 50, 0, 5, 2);
    key(50);
    chk("match", mode, 3);
    acc("prompt", 32'h0105, 500, 0, 1, 2);
    key(123);
    chk("wrong", mode, 0);
    acc("prompt", 32'h0105, 500, 0, 1, 2);
    key(222);
    chk("master", mode, 3);
    acc("lock", 32'h1105, 0, 1, 1, 0);
    chk("locked", nlk > 0, 1);
    acc("lk quick", 32'h1105, 50, 1, 5, 0);
    acc("lk code", 32'h1105, 500, 1, 1, 2);
    acc("lk off", 32'h1105, 500, 0, 1, 3);
    acc("low act", 32'h1101, 500, 0, 1, 2);
    wb(0, `FPAC_ADR_STAT, 0);
    chk("stat", rd, 32'h0000_0420);
    acc("svc", 32'h10505, 500, 0, 1, 2);
    key(50);
    chk("model", {nmd > 0, mvs}, {1'b1, MV});
    key(66);
    chk("dflt", {ndf, nms > 0}, 3);
    wb(0, `FPAC_ADR_CTRL, 0);
    chk("restored", rd, `FPAC_CTRL_RST);
    report_and_stop();
  end
endmodule
